// file: pkg/txcp_pkg.sv
// Package with register map, command field layout and types of the transmit command path
package txcp_pkg;

  // Register byte addresses on the APB slave
  localparam logic [7:0] TXCP_ADDR_DATA = 8'h00;
  localparam logic [7:0] TXCP_ADDR_CTRL = 8'h04;
  localparam logic [7:0] TXCP_ADDR_STAT = 8'h08;
  localparam logic [7:0] TXCP_ADDR_INFO = 8'h0C;
  localparam logic [7:0] TXCP_ADDR_TXST = 8'h10;

  // First command word fields
  localparam int TXCP_CA_IOC = 31;
  localparam int TXCP_CA_ALIGN_HI = 25;
  localparam int TXCP_CA_ALIGN_LO = 24;
  localparam int TXCP_CA_OFF_HI = 20;
  localparam int TXCP_CA_OFF_LO = 16;
  localparam int TXCP_CA_FIRST = 13;
  localparam int TXCP_CA_LAST = 12;
  localparam int TXCP_CA_SIZE_HI = 10;

  // Second command word fields
  localparam int TXCP_CB_TAG_HI = 31;
  localparam int TXCP_CB_TAG_LO = 16;
  localparam int TXCP_CB_LEN_HI = 10;

  // End alignment codes and the word masks they select
  localparam logic [1:0] TXCP_ALIGN_4 = 2'h0;
  localparam logic [1:0] TXCP_ALIGN_16 = 2'h1;
  localparam logic [1:0] TXCP_ALIGN_32 = 2'h2;
  localparam logic [1:0] TXCP_ALIGN_RSV = 2'h3;
  localparam logic [11:0] TXCP_MASK_4 = 12'h000;
  localparam logic [11:0] TXCP_MASK_16 = 12'h003;
  localparam logic [11:0] TXCP_MASK_32 = 12'h007;

  // Control register bits
  localparam int TXCP_CTRL_PAD_EN = 0;
  localparam int TXCP_CTRL_LVL_IE = 1;
  localparam int TXCP_CTRL_DONE_IE = 2;
  localparam int TXCP_CTRL_THR_LO = 8;
  localparam int TXCP_CTRL_THR_HI = 15;
  localparam logic [31:0] TXCP_CTRL_RST = 32'h0000_0000;

  // Status register bits
  localparam int TXCP_ST_ERR = 0;
  localparam int TXCP_ST_LOADED = 1;
  localparam int TXCP_ST_LEVEL = 2;

  // Transmit status word bits below the tag
  localparam int TXCP_TS_ERR = 15;
  localparam int TXCP_TS_FAIL = 0;

  localparam logic [31:0] TXCP_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    TXCP_CMD_A,
    TXCP_CMD_B,
    TXCP_DATA
  } txcp_phase_t;

endpackage

// file: testbench/txcp_host.sv
// Host bus master model: APB transfers and 16-bit word halves
`timescale 1ns/1ns
module txcp_host import txcp_pkg::*; (
  input wire logic clk_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [31:0] prdata_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o
);
  // Idle bus at time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
  end

  // Request held until pready is sampled; released lines are scrambled so stale values never help
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    paddr_o <= ~a;
    pwdata_o <= ~d;
    @(posedge clk_i);
  endtask

  // Low half first, then high half
  task automatic put_word(input logic [31:0] w);
    logic [31:0] r;
    logic e;
    xfer(1'b1, TXCP_ADDR_DATA, {16'h0000, w[15:0]}, r, e);
    xfer(1'b1, TXCP_ADDR_DATA, {16'h0000, w[31:16]}, r, e);
  endtask
endmodule // txcp_host

// file: testbench/txcp_path_tb_top.sv
// Self-checking bench for the transmit command path
`timescale 1ns/1ns
module txcp_path_tb_top import txcp_pkg::*;;
  localparam int DQW = 4;
  logic clk_i, nrst_i, psel, penable, pwrite, pready, pslverr, tx_valid, tx_last, irq;
  logic tx_drain, tx_done, tx_fail;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, tx_word, rd_v;
  logic [3:0] tx_be;
  logic rd_e;
  logic [15:0] tag;
  logic [10:0] ln;
  logic [36:0] ex;
  logic [36:0] expq[$];
  int n_errors, checked, used, cyc;

  // Small data queue so the overflow case is cheap to reach
  txcp_path #(.DQ_WORDS(DQW), .DQ_W(3), .SQ_DEPTH(16), .SQ_AW(4)) DUT (.clk_i(clk_i),
    .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .tx_word_o(tx_word), .tx_be_o(tx_be), .tx_valid_o(tx_valid), .tx_last_o(tx_last),
    .tx_drain_i(tx_drain), .tx_done_i(tx_done), .tx_fail_i(tx_fail), .irq_o(irq));
  txcp_host host (.clk_i(clk_i), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [31:0] bmask(input logic [3:0] b);
    return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction

  function automatic logic [31:0] mk_a(input logic ioc, input logic [1:0] al,
    input logic [4:0] off, input logic fst, input logic lst, input logic [10:0] sz);
    return {ioc, 5'h00, al, 3'h0, off, 2'h0, fst, lst, 1'b0, sz};
  endfunction

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    host.xfer(1'b0, a, 32'h0000_0000, rd_v, rd_e);
    chk(nm, exp, rd_v);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd_v, rd_e);
  endtask

  // Free space first, both commands, then payload; kept words are noted before they are sent
  task automatic buf_put(input logic [31:0] ca, input logic [31:0] cb, input logic pad);
    int off, sz, nw, al, b;
    logic [31:0] w;
    logic [3:0] be;
    off = int'(ca[20:16]);
    sz = int'(ca[10:0]);
    nw = (off + sz + 3) / 4;
    al = (ca[25:24] == TXCP_ALIGN_16) ? 4 : (ca[25:24] == TXCP_ALIGN_32) ? 8 : 1;
    if (pad) nw = (nw + al - 1) / al * al;
    rd(TXCP_ADDR_INFO, 32'(DQW - used), "free_space");
    host.put_word(ca);
    host.put_word(cb);
    for (int i = 0; i < nw; i++) begin
      w = $urandom();
      for (b = 0; b < 4; b++) be[b] = (4 * i + b >= off) && (4 * i + b < off + sz);
      if (be != 4'h0 && used < DQW) begin
        expq.push_back({ca[TXCP_CA_LAST] && (4 * i + 4 >= off + sz), be, w});
        used++;
      end
      host.put_word(w);
    end
  endtask

  task automatic drain(input int n);
    repeat (n) begin
      tx_drain <= 1'b1;
      @(posedge clk_i);
      tx_drain <= 1'b0;
      @(posedge clk_i);
      used--;
    end
  endtask

  // Each kept word meets the oldest note; bytes outside the lanes carry no meaning
  always @(posedge clk_i) begin
    if (nrst_i === 1'b1 && tx_valid === 1'b1) begin
      if (expq.size() == 0) begin
        chk("tx_extra", TXCP_ZERO, {31'h0, tx_valid});
      end else begin
        ex = expq.pop_front();
        chk("tx_be", {28'h000_0000, ex[35:32]}, {28'h000_0000, tx_be});
        chk("tx_last", {31'h0, ex[36]}, {31'h0, tx_last});
        chk("tx_word", ex[31:0] & bmask(ex[35:32]), tx_word & bmask(ex[35:32]));
      end
    end
  end

  initial begin
    nrst_i = 1'b0;
    tx_drain = 1'b0;
    tx_done = 1'b0;
    tx_fail = 1'b0;
    void'($urandom(32'h8b2d));
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    // Reset values and a refused address
    rd(TXCP_ADDR_CTRL, TXCP_CTRL_RST, "ctrl");
    rd(TXCP_ADDR_STAT, TXCP_ZERO, "stat");
    rd(TXCP_ADDR_DATA, TXCP_ZERO, "data_read");
    rd(8'h14, TXCP_ZERO, "unmapped");
    chk("pslverr", 32'h1, {31'h0, rd_e});
    // Single buffer, offset of two bytes, completion flag on the interrupt
    tag = 16'($urandom());
    wr(TXCP_ADDR_CTRL, 32'h0000_0004);
    buf_put(mk_a(1'b1, 2'h0, 5'd2, 1'b1, 1'b1, 11'd5), {tag, 5'h00, 11'd5}, 1'b0);
    drain(2);
    rd(TXCP_ADDR_STAT, 32'h0000_0002, "loaded");
    chk("irq_loaded", 32'h1, {31'h0, irq});
    wr(TXCP_ADDR_STAT, 32'h0000_0002);
    rd(TXCP_ADDR_STAT, TXCP_ZERO, "loaded_clear");
    chk("irq_clear", TXCP_ZERO, {31'h0, irq});
    // Two-buffer packets: tag mismatch, clean, length mismatch
    for (int k = 0; k < 3; k++) begin
      tag = 16'($urandom());
      ln = (k == 2) ? 11'd7 : 11'd6;
      buf_put(mk_a(1'b0, 2'h0, 5'd0, 1'b1, 1'b0, 11'd4), {tag, 5'h00, ln}, 1'b0);
      buf_put(mk_a(1'b0, 2'h0, 5'd3, 1'b0, 1'b1, 11'd2),
        {tag ^ {15'h0000, k == 0}, 5'h00, ln}, 1'b0);
      drain(3);
      rd(TXCP_ADDR_STAT, (k == 1) ? TXCP_ZERO : 32'h1, "pkt_err");
      wr(TXCP_ADDR_STAT, 32'h0000_0001);
    end
    // Every end alignment code with padding accepted
    wr(TXCP_ADDR_CTRL, 32'h0000_0001);
    for (int a = 0; a < 4; a++) begin
      buf_put(mk_a(1'b0, 2'(a), 5'd1, 1'b1, 1'b1, 11'd3), {tag, 5'h00, 11'd3}, 1'b1);
      rd(TXCP_ADDR_INFO, 32'(DQW - 1), "pad_free");
      drain(1);
      rd(TXCP_ADDR_STAT, (a == 3) ? 32'h1 : TXCP_ZERO, "align_err");
      wr(TXCP_ADDR_STAT, 32'h0000_0001);
    end
    // Overfill the data queue
    tag = 16'($urandom());
    wr(TXCP_ADDR_CTRL, TXCP_ZERO);
    buf_put(mk_a(1'b0, 2'h0, 5'd0, 1'b1, 1'b1, 11'd20), {tag, 5'h00, 11'd20}, 1'b0);
    rd(TXCP_ADDR_INFO, TXCP_ZERO, "full");
    rd(TXCP_ADDR_STAT, 32'h1, "overflow_err");
    drain(4);
    // Two transmissions against a level of two: failed with the error flag up, then clean
    wr(TXCP_ADDR_CTRL, 32'h0000_0202);
    rd(TXCP_ADDR_CTRL, 32'h0000_0202, "ctrl_back");
    for (int f = 1; f >= 0; f--) begin
      tx_fail <= f[0];
      tx_done <= 1'b1;
      @(posedge clk_i);
      tx_done <= 1'b0;
      @(posedge clk_i);
      if (f == 1) wr(TXCP_ADDR_STAT, 32'h0000_0001);
    end
    rd(TXCP_ADDR_STAT, 32'h0000_0204, "level");
    chk("irq_level", 32'h1, {31'h0, irq});
    rd(TXCP_ADDR_TXST, {tag, 16'h8001}, "status_fail");
    rd(TXCP_ADDR_TXST, {tag, 16'h0000}, "status_ok");
    rd(TXCP_ADDR_STAT, TXCP_ZERO, "status_empty");
    chk("notes_left", TXCP_ZERO, 32'(expq.size()));
    stop_test();
  end
endmodule // txcp_path_tb_top

// file: verilog/txcp_path.sv
// Transmit buffer command path: APB slave, word pairing, command checks and status queue
// Notes on behaviour
// - Each buffer opens with command word one, then command word two, then payload.
// - Packets may span buffers; first and last bits of command one mark bounds.
// - Packet tag from command two is copied into the status word.
// - Differing tags among buffers of one packet set the error flag.
// - Payload bytes counted; mismatch with packet length sets the error flag.
// - Byte start offset within first 8 words; earlier bytes are dropped.
// - Every following buffer honours its own byte start offset.
// - With padding enabled, extra trailing words up to burst boundary are accepted.
// - Trailing pad up to the selected end alignment is dropped, never sent.
// - Completion bit set signals once the buffer is fully loaded.
// - Every transmission, good or failed, pushes one status word unless the status queue is full.
// - Level flag rises when queued status words reach the programmed level.
// - Writing beyond data queue capacity sets the error flag.
// - Two 16-bit host writes, low half first, form one 32-bit word.
// - Command two must match across buffers of a packet, else error.
// - Commands, skipped bytes and padding take no data queue space.
// - Alignment code 00 is 4, 01 is 16, 10 is 32 bytes, 11 reserved.
// - Completion bit sets the buffer loaded flag, which may drive the interrupt.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
module txcp_path import txcp_pkg::*; #(
  parameter int DQ_WORDS = 1024,
  parameter int DQ_W = 11,
  parameter int SQ_DEPTH = 16,
  parameter int SQ_AW = 4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] tx_word_o,
  output logic [3:0] tx_be_o,
  output logic tx_valid_o,
  output logic tx_last_o,
  input wire logic tx_drain_i,
  input wire logic tx_done_i,
  input wire logic tx_fail_i,
  output logic irq_o
);

  typedef struct packed {
    txcp_phase_t ph;
    logic half_pend;
    logic [15:0] half_lo;
    logic [31:0] cmd_a;
    logic [31:0] cmd_b;
    logic [31:0] first_b;
    logic [11:0] widx;
    logic [11:0] words_tot;
    logic [11:0] bytes_rx;
    logic [DQ_W-1:0] used;
    logic [31:0] ctrl;
    logic transmit_error_flag;
    logic buffer_loaded_flag;
    logic level;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] tx_word;
    logic [3:0] tx_be;
    logic tx_valid;
    logic tx_last;
    logic irq;
  } txcp_state_t;

  txcp_state_t s;
  txcp_state_t next_s;

  logic wr;
  logic rd;
  logic ev_word;
  logic ev_bdone;
  logic ev_keep;
  logic ev_over;
  logic ev_lenbad;
  logic ev_cbbad;
  logic ev_rsv;
  logic [31:0] w;
  logic [11:0] base;
  logic [11:0] pos;
  logic [11:0] off;
  logic [11:0] bend;
  logic [11:0] amask;
  logic [11:0] nwords;
  logic [11:0] nb;
  logic [11:0] bytes_now;
  logic [3:0] be;
  logic dq_inc;
  logic dq_dec;
  logic sf_push;
  logic sf_pop;
  logic [31:0] sf_wdata;
  logic [31:0] sf_rdata;
  logic [SQ_AW:0] sf_cnt;
  logic [SQ_AW:0] thr;
  logic [31:0] stat_word;

  txcp_sfifo #(
    .DEPTH(SQ_DEPTH),
    .AW(SQ_AW)
  ) u_sfifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .push_i(sf_push),
    .wdata_i(sf_wdata),
    .pop_i(sf_pop),
    .rdata_o(sf_rdata),
    .count_o(sf_cnt)
  );

  // Next state: bus slave, word assembly, buffer walk and flags
  always_comb begin
    next_s = s;
    wr = psel_i && penable_i && pwrite_i && s.pready;
    rd = psel_i && penable_i && !pwrite_i && s.pready;
    w = {pwdata_i[15:0], s.half_lo};
    ev_word = 1'b0;
    ev_bdone = 1'b0;
    ev_keep = 1'b0;
    ev_over = 1'b0;
    ev_lenbad = 1'b0;
    ev_cbbad = 1'b0;
    ev_rsv = 1'b0;
    dq_inc = 1'b0;
    dq_dec = tx_drain_i && (s.used != '0);
    sf_pop = 1'b0;
    sf_push = tx_done_i;
    sf_wdata = {s.first_b[TXCP_CB_TAG_HI:TXCP_CB_TAG_LO], TXCP_ZERO[15:0]};
    sf_wdata[TXCP_TS_ERR] = s.transmit_error_flag;
    sf_wdata[TXCP_TS_FAIL] = tx_fail_i;
    off = {7'h00, s.cmd_a[TXCP_CA_OFF_HI:TXCP_CA_OFF_LO]};
    bend = off + {1'b0, s.cmd_a[TXCP_CA_SIZE_HI:0]};
    base = {s.widx[9:0], 2'b00};
    be = 4'h0;
    nb = 12'h000;
    pos = 12'h000;
    amask = TXCP_MASK_4;
    nwords = 12'h000;
    bytes_now = s.bytes_rx;
    thr = (SQ_AW+1)'(s.ctrl[TXCP_CTRL_THR_HI:TXCP_CTRL_THR_LO]);
    stat_word = TXCP_ZERO;
    stat_word[TXCP_ST_ERR] = s.transmit_error_flag;
    stat_word[TXCP_ST_LOADED] = s.buffer_loaded_flag;
    stat_word[TXCP_ST_LEVEL] = s.level;
    stat_word[15:8] = 8'(sf_cnt);
    // One wait state: read data is latched in the first access cycle, write data is taken in the second
    next_s.pready = psel_i && penable_i && !s.pready;
    next_s.pslverr = 1'b0;
    next_s.tx_valid = 1'b0;
    next_s.tx_last = 1'b0;
    if (psel_i && penable_i && !s.pready) begin
      next_s.prdata = TXCP_ZERO;
      unique case (paddr_i)
        TXCP_ADDR_DATA: next_s.prdata = TXCP_ZERO;
        TXCP_ADDR_CTRL: next_s.prdata = s.ctrl;
        TXCP_ADDR_STAT: next_s.prdata = stat_word;
        TXCP_ADDR_INFO: next_s.prdata = 32'(DQ_WORDS) - 32'(s.used);
        TXCP_ADDR_TXST: next_s.prdata = sf_rdata;
        default: next_s.pslverr = 1'b1;
      endcase
    end
    if (rd && paddr_i == TXCP_ADDR_TXST) sf_pop = 1'b1;
    if (wr && paddr_i == TXCP_ADDR_CTRL) next_s.ctrl = pwdata_i;
    // Write-one-to-clear; a new event below still wins
    if (wr && paddr_i == TXCP_ADDR_STAT) begin
      if (pwdata_i[TXCP_ST_ERR]) next_s.transmit_error_flag = 1'b0;
      if (pwdata_i[TXCP_ST_LOADED]) next_s.buffer_loaded_flag = 1'b0;
    end
    // Host halves pair into one word, low half first
    if (wr && paddr_i == TXCP_ADDR_DATA) begin
      next_s.half_pend = !s.half_pend;
      if (!s.half_pend) next_s.half_lo = pwdata_i[15:0];
      ev_word = s.half_pend;
    end
    if (ev_word) begin
      unique case (s.ph)
        TXCP_CMD_A: begin
          next_s.cmd_a = w;
          next_s.ph = TXCP_CMD_B;
        end
        TXCP_CMD_B: begin
          next_s.cmd_b = w;
          next_s.widx = 12'h000;
          off = {7'h00, s.cmd_a[TXCP_CA_OFF_HI:TXCP_CA_OFF_LO]};
          unique case (s.cmd_a[TXCP_CA_ALIGN_HI:TXCP_CA_ALIGN_LO])
            TXCP_ALIGN_4: amask = TXCP_MASK_4;
            TXCP_ALIGN_16: amask = TXCP_MASK_16;
            TXCP_ALIGN_32: amask = TXCP_MASK_32;
            TXCP_ALIGN_RSV: ev_rsv = 1'b1;
          endcase
          // Without pad acceptance the buffer ends on its last word
          if (!s.ctrl[TXCP_CTRL_PAD_EN]) amask = TXCP_MASK_4;
          nwords = (bend + 12'h003) >> 2;
          nwords = (nwords + amask) & ~amask;
          next_s.words_tot = nwords;
          // Packet bounds come from the first and last bits
          if (s.cmd_a[TXCP_CA_FIRST]) begin
            next_s.first_b = w;
            bytes_now = 12'h000;
          end else if (w != s.first_b) begin
            ev_cbbad = 1'b1;
          end
          next_s.bytes_rx = bytes_now;
          if (!s.cmd_a[TXCP_CA_FIRST] &&
              w[TXCP_CB_TAG_HI:TXCP_CB_TAG_LO] !=
              s.first_b[TXCP_CB_TAG_HI:TXCP_CB_TAG_LO]) begin
            ev_cbbad = 1'b1;
          end
          if (nwords == 12'h000) begin
            ev_bdone = 1'b1;
            next_s.ph = TXCP_CMD_A;
            if (s.cmd_a[TXCP_CA_LAST] &&
                bytes_now != {1'b0, w[TXCP_CB_LEN_HI:0]}) ev_lenbad = 1'b1;
          end else begin
            next_s.ph = TXCP_DATA;
          end
        end
        TXCP_DATA: begin
          // Only bytes between start offset and buffer end are kept
          for (int i = 0; i < 4; i++) begin
            pos = base + 12'(i);
            be[i] = (pos >= off) && (pos < bend);
            nb = nb + 12'(be[i]);
          end
          bytes_now = s.bytes_rx + nb;
          next_s.bytes_rx = bytes_now;
          next_s.widx = s.widx + 12'h001;
          if (be != 4'h0) begin
            ev_keep = 1'b1;
            if (s.used == DQ_W'(DQ_WORDS)) begin
              ev_over = 1'b1;
            end else begin
              dq_inc = 1'b1;
              next_s.tx_valid = 1'b1;
              next_s.tx_word = w;
              next_s.tx_be = be;
              next_s.tx_last = s.cmd_a[TXCP_CA_LAST] &&
                               (((bend - 12'h001) >> 2) == s.widx);
            end
          end
          if (s.widx + 12'h001 == s.words_tot) begin
            ev_bdone = 1'b1;
            next_s.ph = TXCP_CMD_A;
            if (s.cmd_a[TXCP_CA_LAST] &&
                bytes_now != {1'b0, s.cmd_b[TXCP_CB_LEN_HI:0]}) ev_lenbad = 1'b1;
          end
        end
        default: next_s.ph = TXCP_CMD_A;
      endcase
    end
    if (ev_bdone && s.cmd_a[TXCP_CA_IOC]) next_s.buffer_loaded_flag = 1'b1;
    if (ev_over || ev_lenbad || ev_cbbad || ev_rsv) next_s.transmit_error_flag = 1'b1;
    next_s.used = s.used + DQ_W'(dq_inc) - DQ_W'(dq_dec);
    next_s.level = (thr != '0) && (sf_cnt >= thr);
    next_s.irq = (s.level && s.ctrl[TXCP_CTRL_LVL_IE]) ||
                 (s.buffer_loaded_flag && s.ctrl[TXCP_CTRL_DONE_IE]);
  end

  // Single state register
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s <= '0;
      s.ph <= TXCP_CMD_A;
      s.ctrl <= TXCP_CTRL_RST;
    end else begin
      s <= next_s;
    end
  end

  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign tx_word_o = s.tx_word;
  assign tx_be_o = s.tx_be;
  assign tx_valid_o = s.tx_valid;
  assign tx_last_o = s.tx_last;
  assign irq_o = s.irq;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence acc_wait_s;
    psel_i && penable_i && !s.pready;
  endsequence

  sequence acc_done_s;
    s.pready ##1 !s.pready;
  endsequence

  apb_wait_state_a: assert property (acc_wait_s |=> acc_done_s)
    else $error("APB access did not complete after one wait state");

  half_pairing_a: assert property (
    wr && paddr_i == TXCP_ADDR_DATA |=> s.half_pend != $past(s.half_pend))
    else $error("Half word write did not toggle pairing state");

  cmd_order_a: assert property (
    ev_word && s.ph == TXCP_CMD_A |=> s.ph == TXCP_CMD_B ##0 !s.tx_valid)
    else $error("First command word not followed by second command phase");

  // The tag must land in the queue itself, not only on its write port
  tag_copy_a: assert property (
    sf_push && sf_cnt == '0 |=>
    sf_rdata[31:16] == $past(s.first_b[TXCP_CB_TAG_HI:TXCP_CB_TAG_LO]))
    else $error("Status word tag differs from packet tag");

  cmdb_mismatch_a: assert property (
    ev_word && s.ph == TXCP_CMD_B && !s.cmd_a[TXCP_CA_FIRST] && w != s.first_b
    |=> s.transmit_error_flag)
    else $error("Second command mismatch did not raise error");

  length_check_a: assert property (ev_lenbad |=> s.transmit_error_flag [*2])
    else $error("Length mismatch did not raise error");

  skip_drop_a: assert property (
    ev_word && s.ph == TXCP_DATA && !ev_keep |=> !s.tx_valid && s.used == $past(s.used)
    - DQ_W'($past(dq_dec)))
    else $error("Skipped or padding word was stored");

  overflow_a: assert property (ev_over |=> s.transmit_error_flag && !s.tx_valid)
    else $error("Overflow did not raise error or was stored");

  loaded_flag_a: assert property (
    ev_bdone && s.cmd_a[TXCP_CA_IOC] |=> s.buffer_loaded_flag)
    else $error("Completion flag missing after buffer load");

  status_push_a: assert property (
    tx_done_i && !sf_pop && sf_cnt != (SQ_AW+1)'(SQ_DEPTH) |=>
    sf_cnt == $past(sf_cnt) + (SQ_AW+1)'(1))
    else $error("Transmission did not queue a status word");

  // Interrupt follows the enable as it stood when the level was registered
  level_flag_a: assert property (
    thr != '0 && sf_cnt >= thr |=> s.level ##1 (s.irq || !$past(s.ctrl[TXCP_CTRL_LVL_IE])))
    else $error("Status level flag or interrupt missing");

endmodule // txcp_path

// file: verilog/txcp_sfifo.sv
// Transmit status queue held in flip-flops
`timescale 1ns/1ns
module txcp_sfifo import txcp_pkg::*; #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic push_i,
  input wire logic [31:0] wdata_i,
  input wire logic pop_i,
  output logic [31:0] rdata_o,
  output logic [AW:0] count_o
);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } txcp_sf_t;

  txcp_sf_t s;
  txcp_sf_t next_s;
  logic [31:0] mem [DEPTH];
  logic do_push;
  logic do_pop;

  // A push into a full queue is dropped; pop on empty is ignored
  always_comb begin
    next_s = s;
    do_push = push_i && (s.cnt != (AW+1)'(DEPTH));
    do_pop = pop_i && (s.cnt != '0);
    if (do_push) next_s.wp = s.wp + AW'(1);
    if (do_pop) next_s.rp = s.rp + AW'(1);
    next_s.cnt = s.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Storage is not reset; only pointers carry meaning
  always_ff @(posedge clk_i) begin
    if (do_push) mem[s.wp] <= wdata_i;
  end

  assign rdata_o = mem[s.rp];
  assign count_o = s.cnt;

endmodule // txcp_sfifo
